// ===== src/swc_pkg.sv
// Package: constants and types of the sleep/wake controller.
// Notes on behaviour
// - Halt with watchdog enabled clears its counter; it keeps counting asleep.
// - Halt clears the powerdown flag and sets the timeout flag.
// - Entering sleep switches the oscillator driver off until a wake event.
// - While asleep every I/O keeps its drive level and enable from before halt.
// - Wake on enabled watchdog timeout or enabled interrupt; execution continues.
// - Powerdown flag set at power-up; timeout flag cleared by watchdog wake.
// - Timeout flag alone tells watchdog wake from interrupt wake.
// - Halt is only taken once the following instruction is prefetched.
// - Wake needs the source enable only, never the global interrupt enable.
// - Interrupt wake with global enable clear: continue after the halt.
// - Interrupt wake with global enable set: next instruction, then vector 0004h.
// - Every wake clears the watchdog counter.
// - Halt with an enabled flag already pending acts as no-operation.
// - Interrupt during or after halt: halt completes, then wake at once.
// - After wake, hold execution for the 18 ms oscillator settling time.
// - Timeout and powerdown flags are readable in the status register.
package swc_pkg;
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned STAB_TIME_US = 18_000;
  localparam int unsigned STAB_CYCLES  = STAB_TIME_US * (CLK_HZ / 1_000_000);
  localparam logic [12:0] IRQ_VECTOR   = 13'h0004;
  localparam logic [7:0] ADR_CTRL    = 8'h00;
  localparam logic [7:0] ADR_IRQ_EN  = 8'h04;
  localparam logic [7:0] ADR_STATUS  = 8'h08;
  localparam logic [7:0] ADR_WDT_CNT = 8'h0C;
  localparam int unsigned CTRL_WDT_EN_BIT = 0;
  localparam int unsigned CTRL_GIE_BIT    = 1;
  localparam int unsigned ST_TIMEOUT_BIT  = 0;
  localparam int unsigned ST_PWRDN_BIT    = 1;
  localparam int unsigned ST_ASLEEP_BIT   = 2;
  localparam int unsigned ST_STAB_BIT     = 3;
  localparam int unsigned ST_WDT_WAKE_BIT = 4;
  localparam logic CTRL_WDT_EN_RST = 1'b1;
  localparam logic CTRL_GIE_RST    = 1'b0;
  localparam logic TIMEOUT_RST     = 1'b1;
  localparam logic PWRDN_RST       = 1'b1;
  typedef enum logic [1:0] {
    SWC_RUN   = 2'b00,
    SWC_SLEEP = 2'b01,
    SWC_STAB  = 2'b10
  } swc_state_type;
  typedef struct packed {
    logic global_irq_enable;
    logic wdt_en;
  } swc_ctrl_type;
  typedef struct packed {
    logic wdt_wake;
    logic stab;
    logic asleep;
    logic powerdown_flag;
    logic timeout_flag;
  } swc_status_type;
endpackage

// ===== src/swc_sync.sv
// Two-flop synchroniser for inputs from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module swc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end
  assign q_o = sync_q;
endmodule
`default_nettype wire

// ===== src/swc_watchdog.sv
// Watchdog counter with prescaler, advanced by ticks of its own clock.
`timescale 1ns/1ps
`default_nettype none
module swc_watchdog #(
  parameter int unsigned PRESC_W = 4,
  parameter int unsigned CNT_W   = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             enable_i,
  input  wire logic             clear_i,
  input  wire logic             tick_i,
  output logic      [CNT_W-1:0] count_o,
  output logic                  timeout_o
);
  initial begin
    if (PRESC_W < 1 || CNT_W < 2 || CNT_W > 32) $error("swc_watchdog: bad widths");
  end
  logic [PRESC_W-1:0] presc_q;
  logic [CNT_W-1:0]   cnt_q;
  logic               to_q;
  // Clear wins over a tick in the same cycle, so sleep starts from zero
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i || !enable_i) begin
      presc_q <= '0;
      cnt_q   <= '0;
    end else if (tick_i) begin
      presc_q <= presc_q + 1'b1;
      if (&presc_q) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i || !enable_i) begin
      to_q <= 1'b0;
    end else begin
      to_q <= tick_i && (&presc_q) && (&cnt_q);
    end
  end
  assign count_o   = cnt_q;
  assign timeout_o = to_q;
endmodule
`default_nettype wire

// ===== src/swc_top.sv
// Sleep entry, wake-up and oscillator settling control with Wishbone registers.
`timescale 1ns/1ps
`default_nettype none
module swc_top
  import swc_pkg::*;
#(
  parameter int unsigned NUM_IRQ     = 8,
  parameter int unsigned IO_W        = 8,
  parameter int unsigned WDT_PRESC_W = 4,
  parameter int unsigned WDT_CNT_W   = 8,
  parameter int unsigned STAB_CYC    = STAB_CYCLES
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               halt_i,
  input  wire logic               prefetch_valid_i,
  input  wire logic               wdt_clear_i,
  input  wire logic [NUM_IRQ-1:0] irq_flag_i,
  input  wire logic               wdt_clk_i,
  input  wire logic [IO_W-1:0]    io_out_i,
  input  wire logic [IO_W-1:0]    io_oe_i,
  output logic      [IO_W-1:0]    io_out_o,
  output logic      [IO_W-1:0]    io_oe_o,
  output logic                    osc_en_o,
  output logic                    core_hold_o,
  output logic                    resume_o,
  output logic                    vector_o,
  output logic      [12:0]        branch_addr_o,
  output logic                    wdt_reset_o
);
  localparam int unsigned STAB_W = $clog2(STAB_CYC + 1);
  initial begin
    if (NUM_IRQ < 1 || NUM_IRQ > 8) $error("swc_top: NUM_IRQ must be 1..8");
    if (IO_W < 1 || IO_W > 32) $error("swc_top: IO_W must be 1..32");
    // The settling hold check looks eight cycles ahead, so shorter delays are refused
    if (STAB_CYC < 8) $error("swc_top: STAB_CYC must be at least 8");
  end

  swc_state_type    state_q;
  swc_ctrl_type     ctrl_q;
  swc_status_type   status;
  logic [NUM_IRQ-1:0] irq_en_q;
  logic             timeout_q;
  logic             powerdown_q;
  logic             wdt_wake_q;
  logic             irq_wake_q;
  logic [STAB_W-1:0] stab_cnt_q;
  logic             osc_en_q;
  logic             resume_q;
  logic             vector_q;
  logic [12:0]      branch_q;
  logic             wdt_rst_q;
  logic [IO_W-1:0]  io_out_q;
  logic [IO_W-1:0]  io_oe_q;
  logic             ack_q;
  logic [31:0]      dat_q;
  logic             wdt_clk_s;
  logic             wdt_clk_prev_q;
  logic             wdt_tick;
  logic             wdt_timeout;
  logic [WDT_CNT_W-1:0] wdt_count;
  logic             pending;
  logic             halt_take;
  logic             halt_nop;
  logic             wdt_wake;
  logic             wake;
  logic             stab_done;
  logic             wdt_clear;

  // Pure gates: no clock edge needed to see a pending source while asleep
  assign pending = |(irq_flag_i & irq_en_q);

  assign halt_take = (state_q == SWC_RUN) && halt_i && prefetch_valid_i && !pending;
  assign halt_nop  = (state_q == SWC_RUN) && halt_i && prefetch_valid_i && pending;
  assign wdt_wake  = (state_q == SWC_SLEEP) && ctrl_q.wdt_en && wdt_timeout;
  // A flag raised after the halt was taken wakes at once in the next cycle
  assign wake      = (state_q == SWC_SLEEP) && (wdt_wake || pending);
  assign stab_done = (state_q == SWC_STAB) && (stab_cnt_q == STAB_W'(STAB_CYC - 1));
  assign wdt_clear = wdt_clear_i || halt_take || wake;

  swc_sync #(
    .W (1)
  ) u_wdt_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (wdt_clk_i),
    .q_o   (wdt_clk_s)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_clk_prev_q <= 1'b0;
    end else begin
      wdt_clk_prev_q <= wdt_clk_s;
    end
  end
  assign wdt_tick = wdt_clk_s && !wdt_clk_prev_q;

  // Ticks come from the watchdog's own clock, so it runs with the core halted
  swc_watchdog #(
    .PRESC_W (WDT_PRESC_W),
    .CNT_W   (WDT_CNT_W)
  ) u_wdt (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .enable_i  (ctrl_q.wdt_en),
    .clear_i   (wdt_clear),
    .tick_i    (wdt_tick),
    .count_o   (wdt_count),
    .timeout_o (wdt_timeout)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= SWC_RUN;
    end else begin
      case (state_q)
        SWC_RUN:   if (halt_take) state_q <= SWC_SLEEP;
        SWC_SLEEP: if (wake) state_q <= SWC_STAB;
        SWC_STAB:  if (stab_done) state_q <= SWC_RUN;
        default:   state_q <= SWC_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != SWC_STAB) begin
      stab_cnt_q <= '0;
    end else begin
      stab_cnt_q <= stab_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_en_q <= 1'b1;
    end else if (halt_take) begin
      osc_en_q <= 1'b0;
    end else if (wake) begin
      osc_en_q <= 1'b1;
    end
  end

  // Status flags; a halt that turns into a no-operation leaves them alone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      powerdown_q <= PWRDN_RST;
      timeout_q   <= TIMEOUT_RST;
    end else if (halt_take) begin
      powerdown_q <= 1'b0;
      timeout_q   <= 1'b1;
    end else if (wdt_wake) begin
      timeout_q <= 1'b0;
    end else if (state_q == SWC_RUN && ctrl_q.wdt_en && wdt_timeout) begin
      timeout_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_wake_q <= 1'b0;
      irq_wake_q <= 1'b0;
    end else if (wake) begin
      wdt_wake_q <= wdt_wake;
      irq_wake_q <= !wdt_wake;
    end
  end

  // Vectoring is decided at resume; the core runs the prefetched word first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resume_q <= 1'b0;
      vector_q <= 1'b0;
      branch_q <= '0;
    end else begin
      resume_q <= stab_done;
      vector_q <= stab_done && irq_wake_q && ctrl_q.global_irq_enable;
      if (stab_done && irq_wake_q && ctrl_q.global_irq_enable) begin
        branch_q <= IRQ_VECTOR;
      end else if (stab_done) begin
        branch_q <= '0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_rst_q <= 1'b0;
    end else begin
      wdt_rst_q <= (state_q == SWC_RUN) && ctrl_q.wdt_en && wdt_timeout;
    end
  end

  // Pins follow the core while running and freeze from the halt on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_out_q <= '0;
      io_oe_q  <= '0;
    end else if (state_q == SWC_RUN && !halt_take) begin
      io_out_q <= io_out_i;
      io_oe_q  <= io_oe_i;
    end
  end

  // Wishbone slave: one wait state, write lands on the ack edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q.wdt_en <= CTRL_WDT_EN_RST;
      ctrl_q.global_irq_enable    <= CTRL_GIE_RST;
      irq_en_q      <= '0;
    end else if (wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == ADR_CTRL) begin
        ctrl_q.wdt_en <= wb_dat_i[CTRL_WDT_EN_BIT];
        ctrl_q.global_irq_enable    <= wb_dat_i[CTRL_GIE_BIT];
      end
      if (wb_adr_i == ADR_IRQ_EN) begin
        irq_en_q <= wb_dat_i[NUM_IRQ-1:0];
      end
    end
  end

  assign status.timeout_flag   = timeout_q;
  assign status.powerdown_flag = powerdown_q;
  assign status.asleep         = (state_q == SWC_SLEEP);
  assign status.stab           = (state_q == SWC_STAB);
  assign status.wdt_wake       = wdt_wake_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= '0;
    end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
      dat_q <= '0;
      case (wb_adr_i)
        ADR_CTRL: begin
          dat_q[CTRL_WDT_EN_BIT] <= ctrl_q.wdt_en;
          dat_q[CTRL_GIE_BIT]    <= ctrl_q.global_irq_enable;
        end
        ADR_IRQ_EN:  dat_q[NUM_IRQ-1:0] <= irq_en_q;
        ADR_STATUS: begin
          dat_q[ST_TIMEOUT_BIT]  <= status.timeout_flag;
          dat_q[ST_PWRDN_BIT]    <= status.powerdown_flag;
          dat_q[ST_ASLEEP_BIT]   <= status.asleep;
          dat_q[ST_STAB_BIT]     <= status.stab;
          dat_q[ST_WDT_WAKE_BIT] <= status.wdt_wake;
        end
        ADR_WDT_CNT: dat_q[WDT_CNT_W-1:0] <= wdt_count;
        default:     dat_q <= '0;
      endcase
    end
  end

  assign wb_ack_o      = ack_q;
  assign wb_dat_o      = dat_q;
  assign io_out_o      = io_out_q;
  assign io_oe_o       = io_oe_q;
  assign osc_en_o      = osc_en_q;
  assign core_hold_o   = (state_q != SWC_RUN);
  assign resume_o      = resume_q;
  assign vector_o      = vector_q;
  assign branch_addr_o = branch_q;
  assign wdt_reset_o   = wdt_rst_q;

  a_halt_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    halt_take |=> !powerdown_q && timeout_q && state_q == SWC_SLEEP)
    else $error("halt did not update flags");

  a_halt_nop_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
    halt_nop |=> $stable(powerdown_q) && $stable(timeout_q) && state_q == SWC_RUN)
    else $error("pending halt was not a no-op");

  a_sleep_osc_off: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == SWC_SLEEP |-> !osc_en_o)
    else $error("oscillator on while asleep");

  a_io_hold_sleep: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q != SWC_RUN && $past(state_q) != SWC_RUN |-> $stable(io_out_o) && $stable(io_oe_o))
    else $error("pins moved while asleep");

  a_wdt_wake_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    wdt_wake |=> !timeout_q && wdt_wake_q && state_q == SWC_STAB)
    else $error("watchdog wake kept timeout flag");

  a_irq_wake_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    wake && !wdt_wake |=> timeout_q && !wdt_wake_q && osc_en_o)
    else $error("interrupt wake changed timeout flag");

  a_wake_clr_wdt: assert property (@(posedge clk_i) disable iff (rst_i)
    wake |=> wdt_count == '0)
    else $error("watchdog not cleared on wake");

  a_stab_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(state_q == SWC_STAB) |-> (!resume_o && core_hold_o) [*8])
    else $error("resumed before settling");

  a_resume_vector: assert property (@(posedge clk_i) disable iff (rst_i)
    stab_done |=> resume_o && (vector_o == $past(irq_wake_q && ctrl_q.global_irq_enable)))
    else $error("wrong vector decision");

  a_no_gie_novec: assert property (@(posedge clk_i) disable iff (rst_i)
    resume_o && !$past(ctrl_q.global_irq_enable) |-> !vector_o)
    else $error("vectored with global enable clear");

  a_halt_prefetch: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == SWC_RUN && halt_i && !prefetch_valid_i |=> state_q == SWC_RUN)
    else $error("halt taken without prefetch");

  a_pending_wake: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == SWC_SLEEP && pending |=> state_q == SWC_STAB ##1 osc_en_o)
    else $error("pending flag did not wake");
endmodule
`default_nettype wire

// ===== bench/swc_core_model.sv
// Behavioural core model that issues halt and drives the pin values.
`timescale 1ns/1ps
`default_nettype none
module swc_core_model (
  input  wire logic       clk_i,
  output logic            halt_o,
  output logic            prefetch_valid_o,
  output logic            wdt_clear_o,
  output logic      [7:0] io_out_o,
  output logic      [7:0] io_oe_o
);
  initial begin
    halt_o = 1'b0;
    prefetch_valid_o = 1'b1;
    wdt_clear_o = 1'b0;
    io_out_o = 8'h00;
    io_oe_o = 8'h00;
  end

  task automatic set_io(input logic [7:0] o, input logic [7:0] e);
    @(posedge clk_i);
    io_out_o <= o;
    io_oe_o <= e;
  endtask

  // The word after halt is a no-operation here, so running it on resume is harmless
  task automatic issue_halt(input logic pf);
    @(posedge clk_i);
    wdt_clear_o <= 1'b1;
    @(posedge clk_i);
    wdt_clear_o <= 1'b0;
    halt_o <= 1'b1;
    prefetch_valid_o <= pf;
    @(posedge clk_i);
    halt_o <= 1'b0;
    prefetch_valid_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking testbench for the sleep/wake controller.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import swc_pkg::*;
  localparam int unsigned STAB = 20;
  logic        clk_i, rst_i, cyc, stb, we, wdt_clk, wdt_run;
  logic        wb_ack_o, halt, pf, wclr, osc_en, hold, resume, vector, wdt_rst;
  logic [7:0]  adr, irq_flag, c_out, c_oe, io_out, io_oe;
  logic [31:0] wdat, rdat, wb_dat_o;
  logic [12:0] baddr;
  logic [3:0]  sel;
  int          wn;
  int          miscompares = 0;
  int          checks = 0;

  swc_top #(.WDT_PRESC_W(1), .WDT_CNT_W(2), .STAB_CYC(STAB)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .halt_i(halt), .prefetch_valid_i(pf), .wdt_clear_i(wclr),
    .irq_flag_i(irq_flag), .wdt_clk_i(wdt_clk), .io_out_i(c_out), .io_oe_i(c_oe),
    .io_out_o(io_out), .io_oe_o(io_oe), .osc_en_o(osc_en), .core_hold_o(hold),
    .resume_o(resume), .vector_o(vector), .branch_addr_o(baddr), .wdt_reset_o(wdt_rst));

  swc_core_model core (.clk_i(clk_i), .halt_o(halt), .prefetch_valid_o(pf),
    .wdt_clear_o(wclr), .io_out_o(c_out), .io_oe_o(c_oe));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Classic cycle: request held until the edge that samples ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    check("wb_ack", {31'h0, wb_ack_o}, 32'h1);
    rdat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    wb(1'b0, a, 32'h0);
    check(what, rdat, exp);
  endtask

  function automatic logic [31:0] st(input logic t, input logic p, input logic s,
                                     input logic w);
    st = 32'h0;
    st[ST_TIMEOUT_BIT] = t;
    st[ST_PWRDN_BIT] = p;
    st[ST_ASLEEP_BIT] = s;
    st[ST_WDT_WAKE_BIT] = w;
  endfunction

  // Watchdog ticks stop once the oscillator is back, so no timeout hits the run phase
  task automatic wait_resume(input int lim);
    wn = 0;
    while (resume !== 1'b1 && wn < lim) begin
      @(negedge clk_i);
      wn++;
      if (osc_en === 1'b1) wdt_run = 1'b0;
      if (resume !== 1'b1) check("hold_wake", hold, 32'h1);
    end
  endtask

  task automatic test_regs();
    rd(ADR_STATUS, st(1, 1, 0, 0), "status_rst");
    rd(ADR_CTRL, {30'h0, CTRL_GIE_RST, CTRL_WDT_EN_RST}, "ctrl_rst");
    wb(1'b1, ADR_STATUS, 32'h0);
    rd(ADR_STATUS, st(1, 1, 0, 0), "status_ro");
    // Low byte lane off: the control write must be dropped
    sel <= 4'hE;
    wb(1'b1, ADR_CTRL, 32'h2);
    sel <= 4'hF;
    rd(ADR_CTRL, {30'h0, CTRL_GIE_RST, CTRL_WDT_EN_RST}, "ctrl_sel");
    rd(8'h20, 32'h0, "unmapped");
    check("osc_rst", osc_en, 32'h1);
    $display("test regs done");
  endtask

  task automatic test_noop();
    wb(1'b1, ADR_IRQ_EN, 32'h80);
    irq_flag <= 8'h80;
    core.issue_halt(1'b1);
    @(negedge clk_i);
    check("hold_noop", hold, 32'h0);
    check("osc_noop", osc_en, 32'h1);
    @(posedge clk_i);
    irq_flag <= 8'h00;
    rd(ADR_STATUS, st(1, 1, 0, 0), "status_noop");
    core.issue_halt(1'b0);
    @(negedge clk_i);
    check("hold_nopf", hold, 32'h0);
    $display("test noop done");
  endtask

  // With global enable set the flag arrives right after halt is taken
  task automatic test_irq_wake(input logic global_irq_enable);
    wb(1'b1, ADR_CTRL, {30'h0, global_irq_enable, 1'b1});
    wb(1'b1, ADR_IRQ_EN, 32'h01);
    core.set_io(8'hA5, 8'h3C);
    repeat (2) @(posedge clk_i);
    core.issue_halt(1'b1);
    if (global_irq_enable) irq_flag <= 8'h01;
    @(negedge clk_i);
    check("osc_sleep", osc_en, 32'h0);
    check("hold_sleep", hold, 32'h1);
    if (!global_irq_enable) begin
      core.set_io(8'h5A, 8'hC3);
      rd(ADR_STATUS, st(1, 0, 1, 0), "status_sleep");
      rd(ADR_WDT_CNT, 32'h0, "wdt_sleep");
      check("io_out", io_out, 32'hA5);
      check("io_oe", io_oe, 32'h3C);
      @(posedge clk_i);
      irq_flag <= 8'h01;
    end
    wait_resume(STAB + 10);
    check("resume", resume, 32'h1);
    check("stab_len", wn >= STAB, 32'h1);
    check("vector", vector, global_irq_enable);
    check("branch", baddr, global_irq_enable ? IRQ_VECTOR : 13'h0);
    @(posedge clk_i);
    irq_flag <= 8'h00;
    rd(ADR_STATUS, st(1, 0, 0, 0), "status_irq");
    $display("test irq wake done");
  endtask

  // A timeout while running asks for a system reset and clears the timeout flag
  task automatic test_wdt_run();
    wdt_run = 1'b1;
    wn = 0;
    while (wdt_rst !== 1'b1 && wn < 100) begin
      @(negedge clk_i);
      wn++;
    end
    wdt_run = 1'b0;
    check("wdt_reset", wdt_rst, 32'h1);
    @(negedge clk_i);
    check("wdt_reset_end", wdt_rst, 32'h0);
    rd(ADR_STATUS, st(0, 0, 0, 0), "status_wdt_run");
    $display("test wdt run done");
  endtask

  task automatic test_wdt_wake();
    wb(1'b1, ADR_IRQ_EN, 32'h0);
    wb(1'b1, ADR_CTRL, 32'h1);
    core.issue_halt(1'b1);
    wdt_run = 1'b1;
    wait_resume(400);
    check("resume_wdt", resume, 32'h1);
    check("vector_wdt", vector, 32'h0);
    rd(ADR_STATUS, st(0, 0, 0, 1), "status_wdt");
    rd(ADR_WDT_CNT, 32'h0, "wdt_after");
    $display("test wdt wake done");
  endtask

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  initial begin
    wdt_clk = 1'b0;
    forever begin
      #185;
      wdt_clk = wdt_run ? ~wdt_clk : 1'b0;
    end
  end

  initial begin
    #300000;
    miscompares++;
    end_of_test();
  end

  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'hF;
    adr = 8'h00;
    wdat = 32'h0;
    irq_flag = 8'h00;
    wdt_run = 1'b0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    test_regs();
    test_noop();
    test_irq_wake(1'b0);
    test_irq_wake(1'b1);
    test_wdt_run();
    test_wdt_wake();
    end_of_test();
  end
endmodule
`default_nettype wire
